/* File: hw/swlirq_top.sv */
// system wake timer, low-voltage control and interrupt pending summary
`default_nettype none
module swlirq_top
  import swlirq_pkg::*;
#(
  parameter int TICK_CYC = swlirq_pkg::TICK_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // tick sources
  input  wire logic        slow_osc_tick,
  input  wire logic        fast_osc_tick,
  // analog detector and power state
  input  wire logic        low_voltage_detect,
  input  wire logic        stop_mode,
  // peripheral sources
  input  wire logic        keypad_flag,
  input  wire logic        keypad_irq_enable,
  input  wire logic        comparator_flag,
  input  wire logic        comparator_irq_enable,
  input  wire logic        modulo_overflow_flag,
  input  wire logic        modulo_overflow_irq_enable,
  // outputs to the system
  output logic             wake_timer_irq,
  output logic             low_voltage_irq,
  output logic             low_voltage_reset,
  output logic             low_voltage_detect_on,
  output logic             slow_osc_powerdown,
  output logic             bandgap_buffer_enable
);
  logic        wake_timeout_flag;

  // wake timer control
  logic        wake_timeout_flag_reg;
  logic        wake_tick_source_select_reg;
  logic        wake_timer_irq_enable_reg;
  logic [2:0]  wake_period_select_reg;
  // power monitor control and pending summary
  logic        low_voltage_flag_reg;
  logic        low_voltage_irq_enable_reg;
  logic        low_voltage_reset_enable_reg;
  logic        low_voltage_stop_enable_reg;
  logic        low_voltage_master_enable_reg;
  logic        bandgap_buffer_enable_reg;
  logic        reset_en_locked_reg;
  logic        master_en_locked_reg;
  logic [7:0]  pending_reg;
  // bus state and registered system outputs
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [3:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_lane0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        wake_irq_reg;
  logic        lv_irq_reg;
  logic        lv_rst_reg;
  logic        lv_on_reg;
  logic        osc_pd_reg;

  swlirq_tick #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .slow_tick  (slow_osc_tick),
    .fast_tick  (fast_osc_tick),
    .src_sel    (wake_tick_source_select_reg),
    .period_sel (wake_period_select_reg),
    .timeout    (wake_timeout_flag)
  );

  // ---- write channel: address and data in either order ----
  wire logic aw_take  = s_axi_awvalid && !aw_held_reg && !bvalid_reg;
  wire logic w_take   = s_axi_wvalid && !w_held_reg && !bvalid_reg;
  wire logic aw_have  = aw_held_reg || aw_take;
  wire logic w_have   = w_held_reg || w_take;
  wire logic wr_fire  = aw_have && w_have && !bvalid_reg;
  wire logic [3:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire logic [7:0] wr_byte = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
  // only byte lane 0 carries register bits; other lanes are ignored
  wire logic wr_lane0 = w_held_reg ? w_lane0_reg : s_axi_wstrb[0];
  wire logic wr_word  = wr_addr[1:0] == 2'h0;
  wire logic wr_wake  = wr_fire && wr_lane0 && wr_word &&
                        wr_addr[3:2] == ADDR_WAKE[3:2];
  wire logic wr_power = wr_fire && wr_lane0 && wr_word &&
                        wr_addr[3:2] == ADDR_POWER[3:2];
  wire logic wr_known = wr_word && (wr_addr[3:2] == ADDR_WAKE[3:2] ||
                        wr_addr[3:2] == ADDR_POWER[3:2] ||
                        wr_addr[3:2] == ADDR_PEND[3:2]);

  // ---- event and flag logic ----
  wire logic wake_ack  = wr_wake && wr_byte[WK_ACK];
  // set wins over a same-cycle acknowledge
  wire logic wake_flag_next = wake_timeout_flag ||
                              (wake_timeout_flag_reg && !wake_ack);
  // detection runs only when master enabled; in stop needs stop enable
  wire logic lv_active = low_voltage_master_enable_reg &&
                         (!stop_mode ||
                          low_voltage_stop_enable_reg);
  wire logic lv_ack    = wr_power && wr_byte[LV_ACK];
  wire logic lv_flag_next = (lv_active && low_voltage_detect) ||
                            (low_voltage_flag_reg && !lv_ack);
  // write-once bits honour only the first write after reset
  wire logic re_write = wr_power && !reset_en_locked_reg;
  wire logic me_write = wr_power && !master_en_locked_reg;

  wire logic [7:0] pending_next = {
    3'h0,
    keypad_flag && keypad_irq_enable,
    comparator_flag && comparator_irq_enable,
    modulo_overflow_flag && modulo_overflow_irq_enable,
    wake_timeout_flag_reg && wake_timer_irq_enable_reg,
    low_voltage_flag_reg && low_voltage_irq_enable_reg &&
      low_voltage_master_enable_reg
  };

  // ---- read path ----
  wire logic ar_take = s_axi_arvalid && !rvalid_reg;
  wire logic rd_word = s_axi_araddr[1:0] == 2'h0;
  wire logic [7:0] wake_view = {wake_timeout_flag_reg, 1'b0,
                                wake_tick_source_select_reg,
                                wake_timer_irq_enable_reg, 1'b0,
                                wake_period_select_reg};
  wire logic [7:0] power_view = {low_voltage_flag_reg, 1'b0,
                                 low_voltage_irq_enable_reg,
                                 low_voltage_reset_enable_reg,
                                 low_voltage_stop_enable_reg,
                                 low_voltage_master_enable_reg, 1'b0,
                                 bandgap_buffer_enable_reg};
  wire logic rd_wake  = rd_word && s_axi_araddr[3:2] == ADDR_WAKE[3:2];
  wire logic rd_power = rd_word && s_axi_araddr[3:2] == ADDR_POWER[3:2];
  wire logic rd_pend  = rd_word && s_axi_araddr[3:2] == ADDR_PEND[3:2];
  wire logic [7:0] rd_byte = rd_wake ? wake_view :
                             rd_power ? power_view :
                             rd_pend ? pending_reg : 8'h00;
  wire logic rd_known = rd_wake || rd_power || rd_pend;

  assign s_axi_awready = aw_held_reg == 1'b0 && bvalid_reg == 1'b0;
  assign s_axi_wready  = w_held_reg == 1'b0 && bvalid_reg == 1'b0;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign wake_timer_irq        = wake_irq_reg;
  assign low_voltage_irq       = lv_irq_reg;
  assign low_voltage_reset     = lv_rst_reg;
  assign low_voltage_detect_on = lv_on_reg;
  assign slow_osc_powerdown    = osc_pd_reg;
  assign bandgap_buffer_enable = bandgap_buffer_enable_reg;

  // bus handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 8'h00;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_have && !wr_fire;
      w_held_reg  <= w_have && !wr_fire;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg  <= s_axi_wdata[7:0];
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // wake timer control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_timeout_flag_reg       <= WAKE_RST[WK_FLAG];
      wake_tick_source_select_reg <= WAKE_RST[WK_SRC];
      wake_timer_irq_enable_reg   <= WAKE_RST[WK_IE];
      wake_period_select_reg      <= WAKE_RST[WK_SEL_W-1:0];
    end else begin
      wake_timeout_flag_reg <= wake_flag_next;
      if (wr_wake) begin
        wake_tick_source_select_reg <= wr_byte[WK_SRC];
        wake_timer_irq_enable_reg   <= wr_byte[WK_IE];
        wake_period_select_reg      <= wr_byte[WK_SEL_W-1:0];
      end
    end
  end

  // power monitor register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_flag_reg          <= POWER_RST[LV_FLAG];
      low_voltage_irq_enable_reg    <= POWER_RST[LV_IE];
      low_voltage_reset_enable_reg  <= POWER_RST[LV_RE];
      low_voltage_stop_enable_reg   <= POWER_RST[LV_SE];
      low_voltage_master_enable_reg <= POWER_RST[LV_ME];
      bandgap_buffer_enable_reg     <= POWER_RST[LV_BG];
      reset_en_locked_reg           <= 1'b0;
      master_en_locked_reg          <= 1'b0;
    end else begin
      low_voltage_flag_reg <= lv_flag_next;
      if (wr_power) begin
        low_voltage_irq_enable_reg  <= wr_byte[LV_IE];
        low_voltage_stop_enable_reg <= wr_byte[LV_SE];
        bandgap_buffer_enable_reg   <= wr_byte[LV_BG];
        reset_en_locked_reg         <= 1'b1;
        master_en_locked_reg        <= 1'b1;
      end
      if (re_write) begin
        low_voltage_reset_enable_reg <= wr_byte[LV_RE];
      end
      if (me_write) begin
        low_voltage_master_enable_reg <= wr_byte[LV_ME];
      end
    end
  end

  // registered system outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg  <= 8'h00;
      wake_irq_reg <= 1'b0;
      lv_irq_reg   <= 1'b0;
      lv_rst_reg   <= 1'b0;
      lv_on_reg    <= 1'b0;
      osc_pd_reg   <= 1'b0;
    end else begin
      pending_reg  <= pending_next;
      wake_irq_reg <= wake_timeout_flag_reg &&
                      wake_timer_irq_enable_reg;
      lv_irq_reg   <= low_voltage_flag_reg &&
                      low_voltage_irq_enable_reg;
      lv_rst_reg   <= low_voltage_flag_reg &&
                      low_voltage_reset_enable_reg &&
                      low_voltage_master_enable_reg;
      lv_on_reg    <= lv_active;
      // only a wake timer turned off and set to the fast source lets the slow oscillator stop
      osc_pd_reg   <= stop_mode &&
                      wake_period_select_reg == WK_OFF &&
                      wake_tick_source_select_reg;
    end
  end
endmodule : swlirq_top
`default_nettype wire

/* File: hw/swlirq_pkg.sv */
// shared constants for the wake timer, low-voltage and pending logic
`default_nettype none
package swlirq_pkg;
  // register byte addresses on the bus
  localparam logic [3:0] ADDR_WAKE   = 4'h0;
  localparam logic [3:0] ADDR_POWER  = 4'h4;
  localparam logic [3:0] ADDR_PEND   = 4'h8;
  // wakeup timer control fields
  localparam int WK_FLAG  = 7;
  localparam int WK_ACK   = 6;
  localparam int WK_SRC   = 5;
  localparam int WK_IE    = 4;
  localparam int WK_SEL_W = 3;
  // power monitor fields
  localparam int LV_FLAG = 7;
  localparam int LV_ACK  = 6;
  localparam int LV_IE   = 5;
  localparam int LV_RE   = 4;
  localparam int LV_SE   = 3;
  localparam int LV_ME   = 2;
  localparam int LV_BG   = 0;
  // pending summary fields
  localparam int PD_KEY  = 4;
  localparam int PD_CMP  = 3;
  localparam int PD_MOD  = 2;
  localparam int PD_WAKE = 1;
  localparam int PD_LV   = 0;
  // reset values
  localparam logic [7:0] WAKE_RST  = 8'h00;
  localparam logic [7:0] POWER_RST = 8'h00;
  // tick timing: 1 ms tick, 100 MHz clock
  localparam int TICK_MS       = 1;
  localparam int CLK_MHZ       = 100;
  localparam int TICK_CYCLES   = TICK_MS * CLK_MHZ * 1000;
  localparam int FAST_DIV      = 32;
  localparam int PERIOD_W      = 11;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    WK_OFF = 3'h0, WK_8 = 3'h1, WK_32 = 3'h2, WK_64 = 3'h3,
    WK_128 = 3'h4, WK_256 = 3'h5, WK_512 = 3'h6, WK_1024 = 3'h7
  } swlirq_period_t;

  // timeout in ticks for each period code
  function automatic logic [PERIOD_W-1:0] period_ticks(
      input logic [2:0] sel);
    unique case (sel)
      WK_8:    period_ticks = 11'h008;
      WK_32:   period_ticks = 11'h020;
      WK_64:   period_ticks = 11'h040;
      WK_128:  period_ticks = 11'h080;
      WK_256:  period_ticks = 11'h100;
      WK_512:  period_ticks = 11'h200;
      WK_1024: period_ticks = 11'h400;
      default: period_ticks = 11'h000;
    endcase
  endfunction : period_ticks
endpackage : swlirq_pkg
`default_nettype wire

/* File: hw/swlirq_tick.sv */
// wake timer tick generator and period counter
`default_nettype none
module swlirq_tick
  import swlirq_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       slow_tick,
  input  wire logic       fast_tick,
  input  wire logic       src_sel,
  input  wire logic [2:0] period_sel,
  output logic            timeout
);
  localparam int DW = $clog2(FAST_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(FAST_DIV - 1);

  logic [DW-1:0]       div_reg;
  logic [DW-1:0]       div_next;
  logic [PERIOD_W-1:0] cnt_reg;
  logic [PERIOD_W-1:0] cnt_next;
  logic                tmo_reg;

  wire logic [PERIOD_W-1:0] limit   = period_ticks(period_sel);
  wire logic                enabled = (period_sel != WK_OFF);
  // 32 kHz source divided down to a trimmed 1 ms tick
  wire logic div_wrap = fast_tick && (div_reg == DIV_LAST);
  wire logic tick     = src_sel ? div_wrap : slow_tick;
  wire logic hit      = enabled && tick &&
                        (cnt_reg == limit - 11'h001);

  assign div_next = !src_sel ? '0 : fast_tick ? div_reg + 1'b1 : div_reg;
  // counter restarts on each timeout, parks at zero when off
  assign cnt_next = !enabled ? '0 : hit ? '0 :
                    tick ? cnt_reg + 11'h001 : cnt_reg;
  assign timeout  = tmo_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
      cnt_reg <= '0;
      tmo_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      tmo_reg <= hit;
    end
  end
endmodule : swlirq_tick
`default_nettype wire

/* File: tb/swlirq_assertions.sv */
// port-level timing checks for the wake timer and low-voltage block
`default_nettype none
module swlirq_checker
  import swlirq_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        stop_mode,
  input wire logic        low_voltage_reset,
  input wire logic        low_voltage_detect_on,
  input wire logic        slow_osc_powerdown
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  wr_block_a: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read not blocked");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  rd_err_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
  powerdown_a: assert property (
    slow_osc_powerdown |-> $past(stop_mode))
    else $error("powerdown outside stop");
  lvd_reset_a: assert property (
    !$past(stop_mode) && low_voltage_reset |-> low_voltage_detect_on)
    else $error("reset without master enable");

  cover property (s_axi_bvalid && s_axi_bready);
  cover property (low_voltage_reset);
  cover property (slow_osc_powerdown);
endmodule : swlirq_checker

bind swlirq_top swlirq_checker chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .stop_mode(stop_mode),
  .low_voltage_reset(low_voltage_reset),
  .low_voltage_detect_on(low_voltage_detect_on),
  .slow_osc_powerdown(slow_osc_powerdown)
);
`default_nettype wire

/* File: tb/swlirq_sources.sv */
// free-running tick sources: slow oscillator and trimmed fast clock
`default_nettype none
module swlirq_sources #(
  parameter int SLOW_GAP = 4,
  parameter int FAST_GAP = 2
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      slow_osc_tick,
  output logic      fast_osc_tick
);
  // gaps shortened so a 1024-tick period stays cheap to simulate
  int sc;
  int fc;
  always_ff @(posedge aclk) begin
    sc <= (!aresetn || sc == SLOW_GAP - 1) ? 0 : sc + 1;
    fc <= (!aresetn || fc == FAST_GAP - 1) ? 0 : fc + 1;
  end
  assign slow_osc_tick = (sc == SLOW_GAP - 1);
  assign fast_osc_tick = (fc == FAST_GAP - 1);
endmodule : swlirq_sources
`default_nettype wire

/* File: tb/swlirq_tb_top.sv */
// register-level tests of the wake timer, low-voltage and pending logic
`default_nettype none
module swlirq_tb_top
  import swlirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SG = 4;
  localparam int FG = 2;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, resp_q;
  logic awready, wready, bvalid, arready, rvalid;
  logic detect, stop, kf, ke, cf, ce, mf, mie;
  logic wk_irq, lv_irq, lv_rst, lv_on, pdown, bg;
  wire logic slow, fast;
  int n_mismatch, samples_checked;
  int per[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};

  swlirq_sources #(.SLOW_GAP(SG), .FAST_GAP(FG)) src (.aclk(aclk),
    .aresetn(aresetn), .slow_osc_tick(slow), .fast_osc_tick(fast));
  swlirq_top #(.TICK_CYC(10)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .slow_osc_tick(slow), .fast_osc_tick(fast),
    .low_voltage_detect(detect), .stop_mode(stop), .keypad_flag(kf),
    .keypad_irq_enable(ke), .comparator_flag(cf),
    .comparator_irq_enable(ce), .modulo_overflow_flag(mf),
    .modulo_overflow_irq_enable(mie), .wake_timer_irq(wk_irq),
    .low_voltage_irq(lv_irq), .low_voltage_reset(lv_rst),
    .low_voltage_detect_on(lv_on), .slow_osc_powerdown(pdown),
    .bandgap_buffer_enable(bg));

  always #5 aclk = ~aclk;

  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask : do_reset

  // address and data offered together, each released once taken
  // hold delays bready so the response must stand
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input int hold = 0);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    repeat (hold) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input int hold = 0);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!(arvalid && arready));
    arvalid <= 1'b0;
    repeat (hold) @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_q = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask : rd

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input int hold = 0);
    rd(a, hold);
    check("read data", rd_q, {24'h0, e});
    check("read resp", resp_q, RESP_OKAY);
  endtask : rd_chk

  task automatic wait_wake(output int n);
    n = 0;
    while (wk_irq !== 1'b1 && n < 5000) begin
      @(posedge aclk);
      n++;
    end
  endtask : wait_wake

  task automatic pulse_detect();
    detect <= 1'b1;
    @(posedge aclk);
    detect <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : pulse_detect

  initial begin
    #300_000;
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    int n;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wstrb, araddr, wdata} = '0;
    {detect, stop, kf, ke, cf, ce, mf, mie} = '0;
    do_reset();
    rd_chk(ADDR_WAKE, 8'h00);
    rd_chk(ADDR_POWER, 8'h00);
    rd_chk(ADDR_PEND, 8'h00);
    rd(4'hC);
    check("unmapped read", rd_q, 32'h0);
    check("unmapped read resp", resp_q, RESP_SLVERR);
    wr(4'hC, 8'hFF, 2);
    check("unmapped write", resp_q, RESP_SLVERR);
    // every flag/enable pairing on the three peripheral sources
    for (int i = 0; i < 4; i++) begin
      {kf, cf, mf} <= {3{i[1]}};
      {ke, ce, mie} <= {3{i[0]}};
      repeat (2) @(posedge aclk);
      rd_chk(ADDR_PEND, (i == 3) ? 8'h1C : 8'h00);
    end
    {kf, cf, mf} <= 3'h0;
    for (int c = 1; c < 8; c++) begin
      wr(ADDR_WAKE, 8'h40);
      wr(ADDR_WAKE, 8'h10 | c[7:0]);
      wait_wake(n);
      check("wake period", 32'(n >= per[c] * SG - SG &&
            n <= per[c] * SG + SG + 6), 1);
      rd_chk(ADDR_WAKE, 8'h90 | c[7:0], 2);
      rd_chk(ADDR_PEND, 8'h02);
    end
    wr(ADDR_WAKE, 8'h40);
    wr(ADDR_WAKE, 8'h31);
    wait_wake(n);
    check("fast period", 32'(n >= 8 * 32 * FG - 32 * FG &&
          n <= 8 * 32 * FG + 6), 1);
    wr(ADDR_WAKE, 8'h41);
    repeat (60) @(posedge aclk);
    check("wake irq masked", wk_irq, 1'b0);
    rd_chk(ADDR_WAKE, 8'h81);
    rd_chk(ADDR_PEND, 8'h00);
    wr(ADDR_WAKE, 8'h50);
    repeat (60) @(posedge aclk);
    rd_chk(ADDR_WAKE, 8'h10);
    stop <= 1'b1;
    wr(ADDR_WAKE, 8'h20);
    repeat (2) @(posedge aclk);
    check("powerdown", pdown, 1'b1);
    wr(ADDR_WAKE, 8'h21);
    repeat (2) @(posedge aclk);
    check("powerdown", pdown, 1'b0);
    wr(ADDR_WAKE, 8'h20);
    stop <= 1'b0;
    repeat (2) @(posedge aclk);
    check("powerdown", pdown, 1'b0);
    // master enable locked off by the first write
    wr(ADDR_POWER, 8'h20);
    pulse_detect();
    rd_chk(ADDR_POWER, 8'h20);
    check("lv irq", lv_irq, 1'b0);
    wr(ADDR_POWER, 8'h3D);
    rd_chk(ADDR_POWER, 8'h29);
    check("detect on", lv_on, 1'b0);
    do_reset();
    wr(ADDR_POWER, 8'h3D);
    rd_chk(ADDR_POWER, 8'h3D);
    check("bandgap", bg, 1'b1);
    wr(ADDR_POWER, 8'h00);
    rd_chk(ADDR_POWER, 8'h14);
    check("bandgap", bg, 1'b0);
    wr(ADDR_POWER, 8'h29);
    pulse_detect();
    check("lv irq", lv_irq, 1'b1);
    check("lv reset", lv_rst, 1'b1);
    rd_chk(ADDR_POWER, 8'hBD);
    rd_chk(ADDR_PEND, 8'h01);
    wr(ADDR_POWER, 8'h69);
    repeat (2) @(posedge aclk);
    rd_chk(ADDR_POWER, 8'h3D);
    check("lv irq", lv_irq, 1'b0);
    wr(ADDR_POWER, 8'h09);
    pulse_detect();
    check("lv irq", lv_irq, 1'b0);
    rd_chk(ADDR_PEND, 8'h00);
    stop <= 1'b1;
    repeat (2) @(posedge aclk);
    check("detect on", lv_on, 1'b1);
    wr(ADDR_POWER, 8'h01);
    repeat (2) @(posedge aclk);
    check("detect on", lv_on, 1'b0);
    stop <= 1'b0;
    report_and_stop();
  end
endmodule : swlirq_tb_top
`default_nettype wire
